// file: core/psc_host.sv
`timescale 1ns/100ps
`default_nettype none
`include "psc_defines.svh"
// ==========================================
// Byte buffer between user side and serialiser
module psc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
  logic [CW-1:0] cnt_q, cnt_d;
  logic rdy_q, rdy_d, vld_q, vld_d, push, pop;

  always_comb
  begin
    push = in_valid && rdy_q;
    pop = out_ready && vld_q;
    wr_d = push ? ((wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1) : wr_q;
    rd_d = pop ? ((rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1) : rd_q;
    cnt_d = cnt_q + CW'(push) - CW'(pop);
    rdy_d = cnt_d != CW'(DEPTH);
    vld_d = cnt_d != '0;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
      rdy_q <= 1'b1;
      vld_q <= 1'b0;
    end
    else if (ce)
    begin
      wr_q <= wr_d;
      rd_q <= rd_d;
      cnt_q <= cnt_d;
      rdy_q <= rdy_d;
      vld_q <= vld_d;
    end
  end

  // Storage has no reset: contents are only read when valid
  always_ff @(posedge clk)
  begin
    if (ce && push)
      mem[wr_q] <= in_data;
  end

  assign in_ready = rdy_q;
  assign out_valid = vld_q;
  assign out_data = mem[rd_q];
endmodule

// ==========================================
// Host end: sequences the load and makes the serial clock
module psc_host #(
  parameter logic [17:0] CF2CK_CYC = 18'(`PSC_T_CF2CK_MIN_US * `PSC_CLK_MHZ),
  parameter logic [17:0] FAIL_CYC =
    18'((`PSC_T_CD2UM_HI_US + `PSC_T_START_SLACK_US) * `PSC_CLK_MHZ)
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic ce,
  psc_link_if.host link,
  input wire logic start,
  input wire logic use_usr_clk,
  input wire logic in_valid,
  input wire logic [7:0] in_data,
  output logic in_ready,
  input wire logic data_end,
  output logic busy,
  output logic configured,
  output logic failed
);
  // Minimum waits round up to whole core cycles
  localparam logic [17:0] REQ_CYC = 18'((`PSC_T_CFG_MIN_NS * `PSC_CLK_MHZ
    + 999) / 1000); // [RQ17]
  localparam logic [9:0] ST2CK_CYC = 10'(`PSC_T_ST2CK_MIN_US * `PSC_CLK_MHZ);
  // Slow-core limit also covers the fast core
  localparam logic [2:0] PER = 3'((`PSC_T_CLK_MIN_PS_LV + `PSC_CLK_PS - 1)
    / `PSC_CLK_PS); // [RQ8]
  localparam logic [2:0] HALF = PER >> 1;
  localparam logic [17:0] DONE_WAIT = 18'(`PSC_DONE_WAIT_SCKS) * 18'(PER);
  localparam logic [1:0] TAIL = 2'(`PSC_TAIL_FALLS);

  logic f_valid, f_pop;
  logic [7:0] f_data;

  psc_fifo #(.WIDTH(8), .DEPTH(8)) u_fifo (
    .clk(core_clk),
    .rst_n(rst_n),
    .ce(ce),
    .in_valid(in_valid),
    .in_data(in_data),
    .in_ready(in_ready),
    .out_valid(f_valid),
    .out_data(f_data),
    .out_ready(f_pop)
  );

  // ==========================================
  // Synchronisers: status, done, init
  logic [2:0] s1_q, s2_q;
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s1_q <= 3'h0;
      s2_q <= 3'h0;
    end
    else if (ce)
    begin
      s1_q <= {link.init_complete, link.config_done, link.status_n};
      s2_q <= s1_q;
    end
  end

  // ==========================================
  // Sequencer and serialiser
  psc_pkg::psc_host_state_t st_q, st_d;
  logic [17:0] cnt_q, cnt_d, cnt_inc;
  logic [9:0] gap_q, gap_d;
  logic [2:0] ph_q, ph_d, ph_nx;
  logic [7:0] sh_q, sh_d;
  logic [3:0] bits_q, bits_d;
  logic [1:0] fall_q, fall_d;
  logic req_n_q, req_n_d, sck_q, sck_d, dat_q, dat_d, uclk_q, uclk_d;
  logic end_q, end_d, busy_q, busy_d, ok_q, ok_d, fail_q, fail_d;

  always_comb
  begin
    st_d = st_q;
    cnt_inc = (cnt_q == 18'h3FFFF) ? cnt_q : cnt_q + 18'h00001;
    cnt_d = cnt_inc;
    gap_d = gap_q;
    ph_nx = (ph_q == PER - 3'h1) ? 3'h0 : ph_q + 3'h1;
    ph_d = ph_q;
    sh_d = sh_q;
    bits_d = bits_q;
    fall_d = fall_q;
    req_n_d = 1'b1;
    sck_d = sck_q;
    dat_d = dat_q;
    uclk_d = 1'b0;
    end_d = end_q | data_end;
    busy_d = 1'b1;
    ok_d = ok_q;
    fail_d = fail_q;
    f_pop = 1'b0;
    case (st_q)
      psc_pkg::H_IDLE, psc_pkg::H_USER:
      begin
        busy_d = 1'b0;
        if (start)
        begin
          st_d = psc_pkg::H_REQ;
          cnt_d = 18'h00000;
          ok_d = 1'b0;
          fail_d = 1'b0;
          busy_d = 1'b1;
        end
      end
      psc_pkg::H_REQ:
      begin
        req_n_d = 1'b0; // [RQ2]
        if (cnt_q >= REQ_CYC - 1) // [RQ2]
        begin
          st_d = psc_pkg::H_WAIT;
          cnt_d = 18'h00000;
          gap_d = 10'h000;
          end_d = 1'b0;
        end
      end
      psc_pkg::H_WAIT:
      begin
        // Gap is measured from the synchronised level, so never short
        gap_d = !s2_q[0] ? 10'h000 :
                (gap_q == 10'h3FF) ? gap_q : gap_q + 10'h001; // [RQ7]
        if (cnt_q >= CF2CK_CYC - 1 && gap_q >= ST2CK_CYC - 1) // [RQ6]
        begin
          st_d = psc_pkg::H_SEND;
          cnt_d = 18'h00000;
          ph_d = 3'h0;
          bits_d = 4'h0;
        end
      end
      psc_pkg::H_SEND:
      begin
        cnt_d = cnt_q;
        if (!s2_q[0])
          st_d = psc_pkg::H_FAIL; // [RQ16]
        else if (s2_q[1])
        begin
          st_d = psc_pkg::H_TAIL;
          ph_d = 3'h0;
          fall_d = 2'h0;
        end
        else if (ph_q != 3'h0)
        begin
          ph_d = ph_nx;
          if (ph_q == HALF)
            sck_d = 1'b1; // [RQ13]
        end
        else if (bits_q != 4'h0)
        begin
          sck_d = 1'b0;
          dat_d = sh_q[0]; // [RQ13]
          sh_d = {1'b0, sh_q[7:1]};
          bits_d = bits_q - 4'h1;
          ph_d = 3'h1;
        end
        else if (f_valid)
        begin
          f_pop = 1'b1;
          sh_d = f_data;
          bits_d = 4'h8;
        end
        else if (end_q)
        begin
          // Data exhausted without done: give up and retry
          cnt_d = cnt_inc;
          if (cnt_q >= DONE_WAIT - 1)
            st_d = psc_pkg::H_FAIL; // [RQ15]
        end
      end
      psc_pkg::H_TAIL:
      begin
        ph_d = ph_nx;
        if (ph_q == 3'h0)
        begin
          if (fall_q == TAIL)
          begin
            st_d = psc_pkg::H_START;
            cnt_d = 18'h00000;
            ph_d = 3'h0;
          end
          else
          begin
            sck_d = 1'b0; // [RQ14]
            fall_d = fall_q + 2'h1;
          end
        end
        else if (ph_q == HALF)
          sck_d = 1'b1;
      end
      psc_pkg::H_START:
      begin
        // Serial clock now parked high until the next load
        ph_d = ph_nx;
        uclk_d = use_usr_clk ? (ph_q < HALF) : 1'b0; // [RQ10]
        dat_d = 1'b0; // [RQ12]
        if (s2_q[2] && s2_q[1])
        begin
          st_d = psc_pkg::H_USER; // [RQ1]
          ok_d = 1'b1;
          busy_d = 1'b0;
        end
        else if (cnt_q >= FAIL_CYC - 1)
          st_d = psc_pkg::H_FAIL; // [RQ15]
      end
      psc_pkg::H_FAIL:
      begin
        fail_d = 1'b1;
        st_d = psc_pkg::H_REQ; // [RQ15]
        cnt_d = 18'h00000;
      end
      default:
        st_d = psc_pkg::H_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_q <= psc_pkg::H_IDLE;
      cnt_q <= 18'h00000;
      gap_q <= 10'h000;
      ph_q <= 3'h0;
      sh_q <= 8'h00;
      bits_q <= 4'h0;
      fall_q <= 2'h0;
      req_n_q <= 1'b1;
      sck_q <= 1'b0; // [RQ11]
      dat_q <= 1'b0; // [RQ12]
      uclk_q <= 1'b0;
      end_q <= 1'b0;
      busy_q <= 1'b0;
      ok_q <= 1'b0;
      fail_q <= 1'b0;
    end
    else if (ce)
    begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      gap_q <= gap_d;
      ph_q <= ph_d;
      sh_q <= sh_d;
      bits_q <= bits_d;
      fall_q <= fall_d;
      req_n_q <= req_n_d;
      sck_q <= sck_d;
      dat_q <= dat_d;
      uclk_q <= uclk_d;
      end_q <= end_d;
      busy_q <= busy_d;
      ok_q <= ok_d;
      fail_q <= fail_d;
    end
  end

  assign link.config_request_n = req_n_q;
  assign link.serial_config_clock = sck_q;
  assign link.serial_config_data = dat_q;
  assign link.user_startup_clock = uclk_q;
  assign busy = busy_q;
  assign configured = ok_q;
  assign failed = fail_q;
endmodule
`default_nettype wire

// file: core/psc_defines.svh
`ifndef PSC_DEFINES_SVH
`define PSC_DEFINES_SVH
// ==========================================
// Core clock
`define PSC_CLK_MHZ 250
`define PSC_CLK_PS 4000
// ==========================================
// Link timing
`define PSC_T_CFG_MIN_NS 500
`define PSC_T_STATUS_MIN_US 45
`define PSC_T_STATUS_HI_US 230
`define PSC_T_STATUS_HOLD_US 50
`define PSC_T_CF2CK_MIN_US 230
`define PSC_T_ST2CK_MIN_US 2
`define PSC_T_CLK_MIN_PS_HV 7500
`define PSC_T_CLK_MIN_PS_LV 15000
`define PSC_F_TOP_MHZ_HV 133
`define PSC_F_TOP_MHZ_LV 66
`define PSC_T_CD2UM_MIN_US 300
`define PSC_T_CD2UM_HI_US 650
`define PSC_T_CD2UM_US 400
`define PSC_T_START_SLACK_US 50
`define PSC_CD2CU_SCKS 4
`define PSC_USR_CLKS 3192
`define PSC_TAIL_FALLS 2
`define PSC_DONE_WAIT_SCKS 8
`define PSC_T_POR_US 100
// ==========================================
// Bitstream
`define PSC_SYNC_BYTE 8'h6A
`define PSC_CFG_BYTES 16
`endif

// file: core/psc_pkg.sv
`default_nettype none
package psc_pkg;
  typedef enum logic [3:0] {
    D_POR, D_CLEAR, D_REL, D_CFG, D_ERR, D_WAIT_CU, D_USR_CNT, D_OSC_CNT,
    D_USER
  } psc_dev_state_t;
  typedef enum logic [3:0] {
    H_IDLE, H_REQ, H_WAIT, H_SEND, H_TAIL, H_START, H_USER, H_FAIL
  } psc_host_state_t;
endpackage
`default_nettype wire

// file: core/psc_link_if.sv
`timescale 1ns/100ps
`default_nettype none
interface psc_link_if;
  logic config_request_n;
  logic serial_config_clock;
  logic serial_config_data;
  logic user_startup_clock;
  logic dev_status_oe;
  logic dev_done_oe;
  logic init_complete;
  logic status_n;
  logic config_done;
  // Pull-ups: a line is high unless someone pulls it low
  assign status_n = ~dev_status_oe;
  assign config_done = ~dev_done_oe;
  modport device (
    input config_request_n,
    input serial_config_clock,
    input serial_config_data,
    input user_startup_clock,
    input status_n,
    output dev_status_oe,
    output dev_done_oe,
    output init_complete
  );
  modport host (
    output config_request_n,
    output serial_config_clock,
    output serial_config_data,
    output user_startup_clock,
    input status_n,
    input config_done,
    input init_complete
  );
endinterface
`default_nettype wire

// file: core/psc_device.sv
// How it works
// [RQ1] User mode shows all three lines high
// [RQ2] Request low 500 ns restarts device
// [RQ3] Device holds status low through power-on
// [RQ4] Done stays low until data complete
// [RQ5] Status pulse 45 to 230 us
// [RQ6] First clock 230 us after request
// [RQ7] First clock 2 us after status
// [RQ8] Serial clock period at least 15 ns
// [RQ9] Oscillator start-up takes 300 to 650 us
// [RQ10] User clock start-up: 3192 clocks supplied
// [RQ11] Serial clock held steady in user mode
// [RQ12] Serial data held steady after configuration
// [RQ13] Bytes sent LSB first, rising-edge sampled
// [RQ14] Two falling edges after done
// [RQ15] Missing done or init restarts configuration
// [RQ16] Device error pulls status low, stops
// [RQ17] Minimum waits counted, rounded up
`timescale 1ns/100ps
`default_nettype none
`include "psc_defines.svh"
module psc_device #(
  parameter logic [16:0] POR_CYC = 17'(`PSC_T_POR_US * `PSC_CLK_MHZ),
  parameter logic [16:0] STATUS_CYC =
    17'(`PSC_T_STATUS_HOLD_US * `PSC_CLK_MHZ),
  parameter logic [16:0] UM_CYC = 17'(`PSC_T_CD2UM_US * `PSC_CLK_MHZ)
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic ce,
  psc_link_if.device link,
  input wire logic use_usr_clk,
  output logic user_mode,
  output logic cfg_error
);
  localparam logic [16:0] CU_CYC = 17'((`PSC_CD2CU_SCKS *
    `PSC_T_CLK_MIN_PS_LV + `PSC_CLK_PS - 1) / `PSC_CLK_PS);
  localparam logic [11:0] USR_CLKS = 12'(`PSC_USR_CLKS);
  localparam logic [15:0] CFG_BITS = 16'(`PSC_CFG_BYTES * 8);
  localparam logic [1:0] TAIL = 2'(`PSC_TAIL_FALLS);

  // ==========================================
  // Link domain, clocked by the serial clock
  logic lrst_n_q;
  logic [15:0] bit_cnt_q, bit_cnt_d;
  logic [7:0] sh_q, sh_d, sh_next;
  logic lerr_q, lerr_d, ldone_q, ldone_d, acc, bad_sync;
  logic [1:0] fall_q, fall_d;

  always_comb
  begin
    acc = !lerr_q && !ldone_q;
    sh_next = {link.serial_config_data, sh_q[7:1]}; // [RQ13]
    bad_sync = bit_cnt_q == 16'h0007 && sh_next != `PSC_SYNC_BYTE;
    bit_cnt_d = acc ? bit_cnt_q + 16'h0001 : bit_cnt_q;
    sh_d = acc ? sh_next : sh_q;
    // Error freezes the shifter until the next request
    lerr_d = lerr_q | (acc && bad_sync); // [RQ16]
    ldone_d = ldone_q | (acc && !bad_sync && bit_cnt_q == CFG_BITS - 1);
    fall_d = (ldone_q && fall_q != TAIL) ? fall_q + 2'h1 : fall_q;
  end

  always_ff @(posedge link.serial_config_clock or negedge lrst_n_q)
  begin
    if (!lrst_n_q)
    begin
      bit_cnt_q <= 16'h0000;
      sh_q <= 8'h00;
      lerr_q <= 1'b0;
      ldone_q <= 1'b0;
    end
    else
    begin
      bit_cnt_q <= bit_cnt_d;
      sh_q <= sh_d;
      lerr_q <= lerr_d;
      ldone_q <= ldone_d;
    end
  end

  // Oscillator start-up (no user clock) waits on the falling edges after done
  always_ff @(negedge link.serial_config_clock or negedge lrst_n_q)
  begin
    if (!lrst_n_q)
      fall_q <= 2'h0;
    else
      fall_q <= fall_d;
  end

  // ==========================================
  // Synchronisers into the oscillator domain
  logic [6:0] s1_q, s2_q, async_in;
  assign async_in = {use_usr_clk, link.user_startup_clock, lerr_q,
                     fall_q == TAIL, ldone_q, link.status_n,
                     link.config_request_n};

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s1_q <= 7'h00;
      s2_q <= 7'h00;
    end
    else if (ce)
    begin
      s1_q <= async_in;
      s2_q <= s1_q;
    end
  end

  // ==========================================
  // Sequencer
  psc_pkg::psc_dev_state_t st_q, st_d;
  logic [16:0] cnt_q, cnt_d, cnt_inc;
  logic [11:0] ucnt_q, ucnt_d;
  logic status_oe_q, status_oe_d, done_oe_q, done_oe_d;
  logic init_q, init_d, lrst_n_d, err_q, err_d, uprev_q, usr_rise;

  always_comb
  begin
    st_d = st_q;
    cnt_inc = (cnt_q == 17'h1FFFF) ? cnt_q : cnt_q + 17'h00001;
    cnt_d = cnt_inc;
    ucnt_d = ucnt_q;
    status_oe_d = status_oe_q;
    done_oe_d = done_oe_q;
    init_d = init_q;
    lrst_n_d = lrst_n_q;
    err_d = err_q;
    usr_rise = s2_q[5] && !uprev_q;
    case (st_q)
      psc_pkg::D_POR:
        if (cnt_q >= POR_CYC - 1) // [RQ3]
        begin
          st_d = psc_pkg::D_REL;
          status_oe_d = 1'b0;
        end
      psc_pkg::D_CLEAR:
        // Pulse stays well inside the legal window after release
        if (cnt_q >= STATUS_CYC - 1 && s2_q[0]) // [RQ5]
        begin
          st_d = psc_pkg::D_REL;
          status_oe_d = 1'b0;
        end
      psc_pkg::D_REL:
        // Host may stretch the pulse by holding the line low
        if (s2_q[1]) // [RQ5]
        begin
          st_d = psc_pkg::D_CFG;
          lrst_n_d = 1'b1;
        end
      psc_pkg::D_CFG:
        if (s2_q[4])
        begin
          st_d = psc_pkg::D_ERR;
          status_oe_d = 1'b1; // [RQ16]
          err_d = 1'b1;
        end
        else if (s2_q[2])
        begin
          done_oe_d = 1'b0; // [RQ4]
          cnt_d = 17'h00000;
          st_d = s2_q[6] ? psc_pkg::D_WAIT_CU : psc_pkg::D_OSC_CNT;
        end
      psc_pkg::D_ERR:
        status_oe_d = 1'b1; // [RQ16]
      psc_pkg::D_WAIT_CU:
        if (cnt_q >= CU_CYC - 1) // [RQ10]
        begin
          st_d = psc_pkg::D_USR_CNT;
          ucnt_d = 12'h000;
        end
      psc_pkg::D_USR_CNT:
        if (usr_rise)
        begin
          ucnt_d = ucnt_q + 12'h001;
          if (ucnt_q == USR_CLKS - 1) // [RQ10]
          begin
            st_d = psc_pkg::D_USER;
            init_d = 1'b1;
          end
        end
      psc_pkg::D_OSC_CNT:
        if (cnt_q >= UM_CYC - 1 && s2_q[3]) // [RQ9]
        begin
          st_d = psc_pkg::D_USER;
          init_d = 1'b1; // [RQ1]
        end
      psc_pkg::D_USER:
        init_d = 1'b1;
      default:
        st_d = psc_pkg::D_POR;
    endcase
    // Request low aborts everything except the power-on hold and a clear already under way
    if (!s2_q[0] && st_q != psc_pkg::D_POR && st_q != psc_pkg::D_CLEAR)
    begin
      st_d = psc_pkg::D_CLEAR; // [RQ2]
      cnt_d = 17'h00000;
      status_oe_d = 1'b1;
      done_oe_d = 1'b1;
      init_d = 1'b0;
      lrst_n_d = 1'b0;
      err_d = 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_q <= psc_pkg::D_POR;
      cnt_q <= 17'h00000;
      ucnt_q <= 12'h000;
      status_oe_q <= 1'b1; // [RQ3]
      done_oe_q <= 1'b1; // [RQ4]
      init_q <= 1'b0;
      lrst_n_q <= 1'b0;
      err_q <= 1'b0;
      uprev_q <= 1'b0;
    end
    else if (ce)
    begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      ucnt_q <= ucnt_d;
      status_oe_q <= status_oe_d;
      done_oe_q <= done_oe_d;
      init_q <= init_d;
      lrst_n_q <= lrst_n_d;
      err_q <= err_d;
      uprev_q <= s2_q[5];
    end
  end

  assign link.dev_status_oe = status_oe_q;
  assign link.dev_done_oe = done_oe_q;
  assign link.init_complete = init_q; // [RQ1]
  assign user_mode = init_q;
  assign cfg_error = err_q;
endmodule
`default_nettype wire

// file: testbench/psc_link_checker.sv
`timescale 1ns/100ps
`default_nettype none
// ==========================================
// Link timing checks between the two ends
module psc_link_checker #(
  parameter int POR_CYC = 200,
  parameter int STATUS_CYC = 50,
  parameter int UM_CYC = 100,
  parameter int CF2CK_CYC = 100
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic config_request_n,
  input wire logic serial_config_clock,
  input wire logic serial_config_data,
  input wire logic user_startup_clock,
  input wire logic init_complete,
  input wire logic status_n,
  input wire logic config_done
);
  // 500 ns and 2 us in core cycles; start-up ceiling keeps the 650:400 ratio
  localparam int REQ_CYC = 125;
  localparam int ST2CK_CYC = 500;
  localparam int UM_TOP = UM_CYC * 13 / 8;
  logic [17:0] por_q, req_q, stl_q, cf_q, sth_q, dn_q, usr_q, fall_q;
  logic sck_q;
  logic usr_clk_q;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  function automatic logic [17:0] sat(input logic [17:0] v);
    return (v == 18'h3FFFF) ? v : v + 18'h00001;
  endfunction
  // ==========================================
  // Interval counters, saturating so long idles never wrap
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      {por_q, req_q, stl_q, cf_q} <= '0;
      {sth_q, dn_q, usr_q, fall_q} <= '0;
      sck_q <= 1'b0;
      usr_clk_q <= 1'b0;
    end
    else
    begin
      por_q <= sat(por_q);
      req_q <= config_request_n ? '0 : sat(req_q);
      stl_q <= status_n ? '0 : sat(stl_q);
      cf_q <= config_request_n ? sat(cf_q) : '0;
      sth_q <= status_n ? sat(sth_q) : '0;
      dn_q <= config_done ? sat(dn_q) : '0;
      usr_q <= !config_done ? '0 :
        (user_startup_clock && !usr_clk_q) ? sat(usr_q) : usr_q;
      fall_q <= !config_done ? '0 :
        (!serial_config_clock && sck_q) ? sat(fall_q) : fall_q;
      sck_q <= serial_config_clock;
      usr_clk_q <= user_startup_clock;
    end
  end
  // ==========================================
  // Assertions
  a_user_lines_high:
    assert property (init_complete && config_request_n |->
      status_n && config_done) else $error("line low in user mode");
  a_req_answer:
    assert property ($fell(config_request_n) |-> ##[0:REQ_CYC]
      (!status_n && !config_done)) else $error("request not answered");
  a_req_width:
    assert property ($rose(config_request_n) |-> req_q >= REQ_CYC)
      else $error("request pulse short");
  a_por_hold:
    assert property (por_q < POR_CYC - 1 |-> !status_n)
      else $error("status released during power-on hold");
  a_done_low:
    assert property (!status_n |-> !config_done)
      else $error("done high while status low");
  a_status_width:
    assert property ($rose(status_n) |-> stl_q >= STATUS_CYC)
      else $error("status pulse short");
  a_status_release:
    assert property ($rose(config_request_n) |-> ##[0:STATUS_CYC] status_n)
      else $error("status held too long");
  a_first_edge:
    assert property ($rose(serial_config_clock) && status_n |->
      cf_q >= CF2CK_CYC && sth_q >= ST2CK_CYC)
      else $error("serial clock too early");
  a_clk_halves:
    assert property ($changed(serial_config_clock) |=>
      $stable(serial_config_clock)) else $error("serial clock too fast");
  a_clk_parked:
    assert property (init_complete && $past(init_complete) |->
      $stable(serial_config_clock)) else $error("clock moves in user mode");
  a_data_held:
    assert property (init_complete && $past(init_complete) &&
      config_request_n |-> $stable(serial_config_data))
      else $error("data moves in user mode");
  a_tail_falls:
    assert property ($rose(init_complete) |-> fall_q >= 2)
      else $error("user mode before two falling edges");
  a_osc_wait:
    assert property ($rose(init_complete) && usr_q == '0 |->
      dn_q >= UM_CYC && dn_q <= UM_TOP) else $error("start-up time off");
  a_usr_count:
    assert property ($rose(init_complete) && usr_q != '0 |->
      usr_q >= 3192 && usr_q <= 3200) else $error("user clock count off");
  a_usr_window:
    assert property ($rose(user_startup_clock) |-> config_done)
      else $error("user clock outside start-up");
  c_osc_start: cover property ($rose(init_complete) && usr_q == '0);
  c_usr_start: cover property ($rose(init_complete) && usr_q != '0);
  c_restart: cover property ($fell(config_request_n) && init_complete);
endmodule
`default_nettype wire

// file: testbench/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
`include "psc_defines.svh"
`define PSC_CHK(what, exp, got) \
  begin \
    checked++; \
    if ((got) !== (exp)) \
    begin \
      bad_count++; \
      $display("unexpected %s: expected %0h seen %0h", what, exp, got); \
    end \
  end
module tb_top;
  // Shortened counts keep the run brief
  localparam int POR_N = 200;
  localparam int STAT_N = 50;
  localparam int UM_N = 100;
  localparam int CF2CK_N = 100;
  localparam int NBYTES = `PSC_CFG_BYTES;
  localparam int LIMIT = 90000;
  typedef struct {
    logic usr;
    logic [7:0] first;
    int nb;
    logic fail;
  } psc_row_t;
  // ==========================================
  // Rows: clock option, first byte, bytes pushed, expected failure
  psc_row_t rows [5] = '{
    '{1'b0, `PSC_SYNC_BYTE, NBYTES, 1'b0},
    '{1'b1, `PSC_SYNC_BYTE, NBYTES, 1'b0},
    '{1'b0, 8'h6B, 1, 1'b1},
    '{1'b1, 8'hEA, 1, 1'b1},
    '{1'b0, `PSC_SYNC_BYTE, 4, 1'b1}
  };
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic start = 1'b0;
  logic use_usr = 1'b0;
  logic in_valid = 1'b0;
  logic [7:0] in_data = 8'h00;
  logic data_end = 1'b0;
  logic in_ready, busy, configured, failed, user_mode, cfg_error;
  logic err_seen = 1'b0;
  logic full_seen = 1'b0;
  logic exp_err;
  logic [7:0] first_q = 8'h00;
  int nbit = 0;
  int nrise = 0;
  int checked = 0;
  int bad_count = 0;
  int cyc = 0;
  int t0;
  always #2 core_clk = ~core_clk;
  psc_link_if link();
  psc_device #(.POR_CYC(17'(POR_N)), .STATUS_CYC(17'(STAT_N)),
    .UM_CYC(17'(UM_N))) i_psc_device (
    .core_clk(core_clk), .rst_n(rst_n), .ce(1'b1), .link(link),
    .use_usr_clk(use_usr), .user_mode(user_mode), .cfg_error(cfg_error));
  psc_host #(.CF2CK_CYC(18'(CF2CK_N)), .FAIL_CYC(18'h04E20)) i_psc_host (
    .core_clk(core_clk), .rst_n(rst_n), .ce(1'b1), .link(link),
    .start(start), .use_usr_clk(use_usr), .in_valid(in_valid),
    .in_data(in_data), .in_ready(in_ready), .data_end(data_end),
    .busy(busy), .configured(configured), .failed(failed));
  psc_link_checker #(.POR_CYC(POR_N), .STATUS_CYC(STAT_N), .UM_CYC(UM_N),
    .CF2CK_CYC(CF2CK_N)) i_psc_link_checker (
    .core_clk(core_clk), .rst_n(rst_n),
    .config_request_n(link.config_request_n),
    .serial_config_clock(link.serial_config_clock),
    .serial_config_data(link.serial_config_data),
    .user_startup_clock(link.user_startup_clock),
    .init_complete(link.init_complete), .status_n(link.status_n),
    .config_done(link.config_done));
  // ==========================================
  // Wire monitor: first byte and data edges since the last request
  always @(posedge link.serial_config_clock or negedge link.config_request_n)
  begin
    if (!link.config_request_n)
    begin
      nbit <= 0;
      nrise <= 0;
    end
    else
    begin
      if (nbit < 8)
        first_q <= {link.serial_config_data, first_q[7:1]};
      nbit <= nbit + 1;
      if (!link.config_done)
        nrise <= nrise + 1;
    end
  end
  always @(posedge core_clk)
  begin
    cyc <= cyc + 1;
    if (cfg_error === 1'b1)
      err_seen <= 1'b1;
    if (in_valid && in_ready === 1'b0)
      full_seen <= 1'b1;
    if (cyc == LIMIT)
    begin
      bad_count++;
      tally_and_finish();
    end
  end
  // ==========================================
  // Tasks
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  function automatic logic pick(input int sel);
    case (sel)
      0: return configured;
      1: return failed;
      default: return link.status_n;
    endcase
  endfunction
  task automatic wait_hi(input int sel, input int lim);
    int n;
    n = 0;
    while (pick(sel) !== 1'b1 && n < lim)
    begin
      @(posedge core_clk);
      n++;
    end
    `PSC_CHK("wait", 1'b1, pick(sel))
  endtask
  // Valid stays up between bytes; a full buffer simply stalls the loop
  task automatic send_stream(input logic [7:0] b0, input int nb);
    int i;
    int n;
    i = 0;
    n = 0;
    full_seen = 1'b0;
    in_valid <= 1'b1;
    in_data <= b0;
    while (i < nb && n < LIMIT)
    begin
      @(posedge core_clk);
      n++;
      if (in_ready === 1'b1)
      begin
        i++;
        in_data <= 8'(i * 8'h25 + 8'h11);
      end
    end
    in_valid <= 1'b0;
    data_end <= 1'b1;
    @(posedge core_clk);
    data_end <= 1'b0;
  endtask
  // ==========================================
  // Main sequence
  initial
  begin
    repeat (6) @(posedge core_clk);
    rst_n <= 1'b1;
    wait_hi(2, 4 * POR_N);
    foreach (rows[k])
    begin
      err_seen = 1'b0;
      exp_err = rows[k].first !== `PSC_SYNC_BYTE;
      use_usr <= rows[k].usr;
      @(posedge core_clk);
      start <= 1'b1;
      @(posedge core_clk);
      start <= 1'b0;
      // End mark given during the request would be dropped
      repeat (8) @(posedge core_clk);
      wait_hi(2, 1000);
      send_stream(rows[k].first, rows[k].nb);
      if (rows[k].fail)
      begin
        wait_hi(1, 30000);
        // Restart pulse is 125 cycles, so the request is low by now
        repeat (8) @(posedge core_clk);
        wait_hi(2, 1000);
        send_stream(`PSC_SYNC_BYTE, NBYTES);
      end
      wait_hi(0, 30000);
      `PSC_CHK("user mode", 1'b1, user_mode)
      `PSC_CHK("request", 1'b1, link.config_request_n)
      `PSC_CHK("lines", 2'h3, {link.status_n, link.config_done})
      `PSC_CHK("busy", 1'b0, busy)
      `PSC_CHK("failed", rows[k].fail, failed)
      `PSC_CHK("error seen", exp_err, err_seen)
      `PSC_CHK("first byte", `PSC_SYNC_BYTE, first_q)
      `PSC_CHK("data edges", NBYTES * 8, nrise)
      `PSC_CHK("buffer full", 1'b1, full_seen)
    end
    // Second reset from user mode: lines drop, power-on hold again
    rst_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    `PSC_CHK("status in reset", 1'b0, link.status_n)
    `PSC_CHK("done in reset", 1'b0, link.config_done)
    `PSC_CHK("mode in reset", 1'b0, user_mode)
    rst_n <= 1'b1;
    t0 = cyc;
    wait_hi(2, 4 * POR_N);
    `PSC_CHK("hold length", 1'b1, (cyc - t0) >= POR_N)
    tally_and_finish();
  end
endmodule
`default_nettype wire
